// ### verilog/fan_loop_pkg.sv
`default_nettype none
package fan_loop_pkg;
	// Register indices; byte address on APB is four times the index
	localparam logic [7:0] IDX_ADAPT_CTRL = 8'h0b;
	localparam logic [7:0] IDX_CYCLE_CTRL = 8'h0c;
	localparam logic [7:0] IDX_ACOUSTIC_A = 8'h1a;
	localparam logic [7:0] IDX_ACOUSTIC_B = 8'h1b;
	localparam logic [7:0] IDX_TARGET_Z1 = 8'h5a;
	localparam logic [7:0] IDX_TARGET_Z2 = 8'h5b;
	localparam logic [7:0] IDX_HYST = 8'h64;
	localparam logic [7:0] IDX_LOW_Z1 = 8'h70;
	localparam logic [7:0] IDX_HIGH_Z1 = 8'h71;
	localparam logic [7:0] IDX_LOW_Z2 = 8'h72;
	localparam logic [7:0] IDX_HIGH_Z2 = 8'h73;
	localparam logic [7:0] IDX_THRESH_Z1 = 8'h74;
	localparam logic [7:0] IDX_THRESH_Z2 = 8'h75;
	localparam logic [7:0] IDX_TEMP_Z1 = 8'h76;
	localparam logic [7:0] IDX_TEMP_Z2 = 8'h77;
	localparam logic [7:0] IDX_STATUS = 8'h78;

	// Field positions
	localparam int EN_Z1_BIT = 0;
	localparam int EN_Z2_BIT = 1;
	localparam int CAP_Z1_BIT = 2;
	localparam int CAP_Z2_BIT = 3;
	localparam int CYC_Z1_LSB = 0;
	localparam int CYC_Z2_LSB = 3;
	localparam int HYST_LSB = 4;
	localparam int AC_EN_LO_BIT = 0;
	localparam int AC_EN_HI_BIT = 1;

	// Reset values; temperatures are offset-64 codes, 0x00 is -64 C
	localparam logic [7:0] RST_ADAPT_CTRL = 8'h00;
	localparam logic [7:0] RST_CYCLE_CTRL = 8'h00;
	localparam logic [7:0] RST_ACOUSTIC = 8'h00;
	localparam logic [7:0] RST_TARGET = 8'ha4;
	localparam logic [7:0] RST_HYST = 8'h40;
	localparam logic [7:0] RST_LOW = 8'h5e;
	localparam logic [7:0] RST_HIGH = 8'hb9;
	localparam logic [7:0] RST_THRESH = 8'h5a;
	localparam logic [7:0] THRESH_FLOOR = 8'h00;

	// Loop figures
	localparam logic [11:0] SHORT_BASE = 12'h008;
	localparam logic [10:0] QUARTER_STILL = 11'h001;
	localparam logic [7:0] DUTY_STEP = 8'h10;

	typedef struct packed {
		logic enable;
		logic [2:0] cycle_code;
		logic [7:0] target;
		logic [3:0] hyst;
		logic [7:0] low;
		logic [7:0] high;
	} zone_cfg_s;
endpackage
`default_nettype wire

// ### verilog/threshold_zone.sv
`timescale 1ns/100ps
`default_nettype none
module threshold_zone
	import fan_loop_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic temp_valid,
	input wire logic [9:0] temp,
	input wire zone_cfg_s cfg,
	input wire logic sw_wr,
	input wire logic [7:0] sw_data,
	output logic [7:0] fan_on_threshold
);
	logic [11:0] cnt_reg;
	logic [9:0] prev_reg;
	logic [11:0] short_mask;
	logic [11:0] long_last;
	logic short_hit;
	logic long_hit;
	logic signed [11:0] temp_q;
	logic signed [11:0] thr_q;
	logic signed [11:0] tgt_q;
	logic signed [11:0] tgt_hyst_q;
	logic signed [11:0] rise_q;
	logic signed [11:0] acc;
	logic [7:0] thr_next;

	always_comb begin
		short_mask = (SHORT_BASE << cfg.cycle_code) - 12'h001;
		long_last = ((SHORT_BASE << cfg.cycle_code) << 1) - 12'h001;
		short_hit = (cnt_reg & short_mask) == short_mask;
		long_hit = cnt_reg == long_last;
	end

	// Counter wraps at the long period so short and long stay aligned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 12'h000;
		end else if (temp_valid) begin
			cnt_reg <= long_hit ? 12'h000 : cnt_reg + 12'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= 10'h000;
		end else if (temp_valid) begin
			prev_reg <= temp;
		end
	end

	always_comb begin
		temp_q = {2'b00, temp};
		thr_q = {2'b00, fan_on_threshold, 2'b00};
		tgt_q = {2'b00, cfg.target, 2'b00};
		tgt_hyst_q = tgt_q - {6'h00, cfg.hyst, 2'b00};
		rise_q = temp_q - {2'b00, prev_reg};
		acc = {4'h0, fan_on_threshold};
		// Below the threshold the loop rests; disabled zones never move
		if (cfg.enable && temp_valid && temp_q >= thr_q) begin
			// Between low limit and target minus hysteresis nothing happens
			if (short_hit && temp_q > tgt_hyst_q && rise_q > $signed({1'b0, QUARTER_STILL})) begin
				acc = acc - (rise_q >>> 1);
			end
			if (long_hit) begin
				if (temp_q > tgt_q) begin
					acc = acc - 12'sd1;
				end else if (temp_q < {2'b00, cfg.low, 2'b00} && fan_on_threshold < cfg.high
						&& fan_on_threshold < cfg.target && temp_q > thr_q) begin
					acc = acc + 12'sd1;
				end
			end
			if (acc < 12'sd0) begin
				acc = {4'h0, THRESH_FLOOR};
			end
			if (acc > $signed({4'h0, cfg.high})) begin
				acc = {4'h0, cfg.high};
			end
		end
		thr_next = acc[7:0];
	end

	// Software write wins: it sets a fresh starting point for the loop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fan_on_threshold <= RST_THRESH;
		end else if (sw_wr) begin
			fan_on_threshold <= sw_data;
		end else begin
			fan_on_threshold <= thr_next;
		end
	end
endmodule
`default_nettype wire

// ### verilog/duty_ramp.sv
`timescale 1ns/100ps
`default_nettype none
module duty_ramp
	import fan_loop_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic update,
	input wire logic acoustic_en,
	input wire logic [7:0] computed_duty,
	output logic [7:0] duty
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty <= 8'h00;
		end else if (update) begin
			if (!acoustic_en) begin
				duty <= computed_duty;
			end else if (computed_duty > duty) begin
				duty <= (computed_duty - duty > DUTY_STEP) ? duty + DUTY_STEP : computed_duty;
			end else if (computed_duty < duty) begin
				duty <= (duty - computed_duty > DUTY_STEP) ? duty - DUTY_STEP : computed_duty;
			end
		end
	end
endmodule
`default_nettype wire

// ### verilog/adaptive_fan_threshold_loop.sv
// Operation
// - Between low limit and target minus hysteresis, threshold is unchanged.
// - Above target minus hysteresis, short cycle lowers threshold by twice the rise.
// - A rise of at most a quarter degree since the previous reading makes no short-cycle cut.
// - Between target minus hysteresis and target, long cycle changes nothing.
// - Above target, each long cycle lowers threshold one degree, plus short cuts.
// - Raise only if temp below low, threshold below high and target, temp above it.
// - Adjusted threshold never exceeds the zone's high limit.
// - Adjusted threshold never goes below minus sixty-four degrees.
// - Temperature below threshold suspends adjustment for that zone.
// - Control bit 0 enables zone 1, bit 1 enables zone 2.
// - Disabled zone keeps its programmed threshold as plain automatic control.
// - Capture bit set and trip asserted copy temperature into target register.
// - Capture bit clear: trip ignored, target keeps programmed value.
// - Without acoustic mode, computed duty is applied at once.
// - Acoustic mode moves duty by a fixed step toward the computed value.
// - Falling computed duty lowers duty by one step each update, no delay.
// - Acoustic mode is enabled separately for each PWM output.
// - Short cycle every n monitoring cycles, long every 2n, n from 3-bit code.
// - Eight-bit target registers per zone and a 4-bit hysteresis field.
`timescale 1ns/100ps
`default_nettype none
module adaptive_fan_threshold_loop
	import fan_loop_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic temp_valid,
	input wire logic [9:0] zone1_temp,
	input wire logic [9:0] zone2_temp,
	input wire logic thermal_trip_pin_n,
	input wire logic duty_update,
	input wire logic [31:0] computed_duty,
	output logic [7:0] zone1_threshold,
	output logic [7:0] zone2_threshold,
	output logic [31:0] pwm_duty
);
	logic [7:0] adapt_ctrl_reg;
	logic [7:0] cycle_ctrl_reg;
	logic [7:0] acoustic_a_reg;
	logic [7:0] acoustic_b_reg;
	logic [7:0] target1_reg;
	logic [7:0] target2_reg;
	logic [7:0] hyst_reg;
	logic [7:0] low1_reg;
	logic [7:0] high1_reg;
	logic [7:0] low2_reg;
	logic [7:0] high2_reg;
	logic trip_prev_reg;
	logic [1:0] captured_reg;
	logic trip_edge;
	logic access;
	logic wr_en;
	logic [9:0] idx;
	logic mapped;
	logic [7:0] rd_data;
	zone_cfg_s cfg1;
	zone_cfg_s cfg2;
	logic [3:0] ac_en;
	logic [7:0] thr1;
	logic [7:0] thr2;
	logic [31:0] duty_w;

	// One wait state: answer comes on the second access-phase edge
	assign access = psel && penable && !pready;
	assign wr_en = access && pwrite;
	assign idx = paddr[11:2];
	assign trip_edge = trip_prev_reg && !thermal_trip_pin_n;

	always_comb begin
		mapped = 1'b1;
		rd_data = 8'h00;
		if (idx == {2'b00, IDX_ADAPT_CTRL}) begin
			rd_data = adapt_ctrl_reg;
		end else if (idx == {2'b00, IDX_CYCLE_CTRL}) begin
			rd_data = cycle_ctrl_reg;
		end else if (idx == {2'b00, IDX_ACOUSTIC_A}) begin
			rd_data = acoustic_a_reg;
		end else if (idx == {2'b00, IDX_ACOUSTIC_B}) begin
			rd_data = acoustic_b_reg;
		end else if (idx == {2'b00, IDX_TARGET_Z1}) begin
			rd_data = target1_reg;
		end else if (idx == {2'b00, IDX_TARGET_Z2}) begin
			rd_data = target2_reg;
		end else if (idx == {2'b00, IDX_HYST}) begin
			rd_data = hyst_reg;
		end else if (idx == {2'b00, IDX_LOW_Z1}) begin
			rd_data = low1_reg;
		end else if (idx == {2'b00, IDX_HIGH_Z1}) begin
			rd_data = high1_reg;
		end else if (idx == {2'b00, IDX_LOW_Z2}) begin
			rd_data = low2_reg;
		end else if (idx == {2'b00, IDX_HIGH_Z2}) begin
			rd_data = high2_reg;
		end else if (idx == {2'b00, IDX_THRESH_Z1}) begin
			rd_data = thr1;
		end else if (idx == {2'b00, IDX_THRESH_Z2}) begin
			rd_data = thr2;
		end else if (idx == {2'b00, IDX_TEMP_Z1}) begin
			rd_data = zone1_temp[9:2];
		end else if (idx == {2'b00, IDX_TEMP_Z2}) begin
			rd_data = zone2_temp[9:2];
		end else if (idx == {2'b00, IDX_STATUS}) begin
			rd_data = {6'h00, captured_reg};
		end else begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access;
			pslverr <= access && !mapped;
			if (access && !pwrite) begin
				prdata <= {24'h00_0000, rd_data};
			end
		end
	end

	function automatic logic hit(input logic [9:0] a, input logic [7:0] i);
		hit = a == {2'b00, i};
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adapt_ctrl_reg <= RST_ADAPT_CTRL;
			cycle_ctrl_reg <= RST_CYCLE_CTRL;
			acoustic_a_reg <= RST_ACOUSTIC;
			acoustic_b_reg <= RST_ACOUSTIC;
			hyst_reg <= RST_HYST;
			low1_reg <= RST_LOW;
			high1_reg <= RST_HIGH;
			low2_reg <= RST_LOW;
			high2_reg <= RST_HIGH;
		end else if (wr_en) begin
			if (hit(idx, IDX_ADAPT_CTRL)) begin
				adapt_ctrl_reg <= pwdata[7:0];
			end
			if (hit(idx, IDX_CYCLE_CTRL)) begin
				cycle_ctrl_reg <= pwdata[7:0];
			end
			if (hit(idx, IDX_ACOUSTIC_A)) begin
				acoustic_a_reg <= pwdata[7:0];
			end
			if (hit(idx, IDX_ACOUSTIC_B)) begin
				acoustic_b_reg <= pwdata[7:0];
			end
			if (hit(idx, IDX_HYST)) begin
				hyst_reg <= pwdata[7:0];
			end
			if (hit(idx, IDX_LOW_Z1)) begin
				low1_reg <= pwdata[7:0];
			end
			if (hit(idx, IDX_HIGH_Z1)) begin
				high1_reg <= pwdata[7:0];
			end
			if (hit(idx, IDX_LOW_Z2)) begin
				low2_reg <= pwdata[7:0];
			end
			if (hit(idx, IDX_HIGH_Z2)) begin
				high2_reg <= pwdata[7:0];
			end
		end
	end

	// Trip is caught on its falling edge so a held trip copies once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_prev_reg <= 1'b1;
		end else begin
			trip_prev_reg <= thermal_trip_pin_n;
		end
	end

	// Capture beats a software write landing in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			target1_reg <= RST_TARGET;
			target2_reg <= RST_TARGET;
		end else begin
			if (trip_edge && adapt_ctrl_reg[CAP_Z1_BIT]) begin
				target1_reg <= zone1_temp[9:2];
			end else if (wr_en && hit(idx, IDX_TARGET_Z1)) begin
				target1_reg <= pwdata[7:0];
			end
			if (trip_edge && adapt_ctrl_reg[CAP_Z2_BIT]) begin
				target2_reg <= zone2_temp[9:2];
			end else if (wr_en && hit(idx, IDX_TARGET_Z2)) begin
				target2_reg <= pwdata[7:0];
			end
		end
	end

	// Sticky capture indication, cleared by writing ones; capture wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			captured_reg <= 2'b00;
		end else begin
			captured_reg <= (captured_reg & ~((wr_en && hit(idx, IDX_STATUS)) ? pwdata[1:0] : 2'b00))
				| {trip_edge && adapt_ctrl_reg[CAP_Z2_BIT], trip_edge && adapt_ctrl_reg[CAP_Z1_BIT]};
		end
	end

	always_comb begin
		cfg1.enable = adapt_ctrl_reg[EN_Z1_BIT];
		cfg1.cycle_code = cycle_ctrl_reg[CYC_Z1_LSB +: 3];
		cfg1.target = target1_reg;
		cfg1.hyst = hyst_reg[HYST_LSB +: 4];
		cfg1.low = low1_reg;
		cfg1.high = high1_reg;
		cfg2.enable = adapt_ctrl_reg[EN_Z2_BIT];
		cfg2.cycle_code = cycle_ctrl_reg[CYC_Z2_LSB +: 3];
		cfg2.target = target2_reg;
		cfg2.hyst = hyst_reg[HYST_LSB +: 4];
		cfg2.low = low2_reg;
		cfg2.high = high2_reg;
		ac_en = {acoustic_b_reg[AC_EN_HI_BIT], acoustic_b_reg[AC_EN_LO_BIT],
			acoustic_a_reg[AC_EN_HI_BIT], acoustic_a_reg[AC_EN_LO_BIT]};
	end

	threshold_zone u_zone1 (
		.pclk(pclk),
		.presetn(presetn),
		.temp_valid(temp_valid),
		.temp(zone1_temp),
		.cfg(cfg1),
		.sw_wr(wr_en && hit(idx, IDX_THRESH_Z1)),
		.sw_data(pwdata[7:0]),
		.fan_on_threshold(thr1)
	);

	threshold_zone u_zone2 (
		.pclk(pclk),
		.presetn(presetn),
		.temp_valid(temp_valid),
		.temp(zone2_temp),
		.cfg(cfg2),
		.sw_wr(wr_en && hit(idx, IDX_THRESH_Z2)),
		.sw_data(pwdata[7:0]),
		.fan_on_threshold(thr2)
	);

	assign zone1_threshold = thr1;
	assign zone2_threshold = thr2;

	// Each output ramps on its own, even when two share one zone
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pwm
			duty_ramp u_ramp (
				.pclk(pclk),
				.presetn(presetn),
				.update(duty_update),
				.acoustic_en(ac_en[g]),
				.computed_duty(computed_duty[8*g +: 8]),
				.duty(duty_w[8*g +: 8])
			);
		end
	endgenerate

	assign pwm_duty = duty_w;
endmodule
`default_nettype wire

// ### tb/fan_loop_sva.sv
`timescale 1ns/100ps
`default_nettype none
module fan_loop_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic temp_valid,
	input wire logic duty_update,
	input wire logic [31:0] computed_duty,
	input wire logic [7:0] zone1_threshold,
	input wire logic [7:0] zone2_threshold,
	input wire logic [31:0] pwm_duty
);
	logic sw_wr;
	// A software write of a threshold lands at the edge the access is taken
	assign sw_wr = psel && penable && pwrite && !pready;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	rdata_hold_a: assert property (!(psel && penable && !pwrite && !pready) |=> $stable(prdata))
		else $error("read data moved without a read");
	z1_hold_a: assert property (!temp_valid && !sw_wr |=> $stable(zone1_threshold))
		else $error("zone 1 threshold moved between monitoring cycles");
	z2_hold_a: assert property (!temp_valid && !sw_wr |=> $stable(zone2_threshold))
		else $error("zone 2 threshold moved between monitoring cycles");
	raise_step_a: assert property (temp_valid && !sw_wr |=>
		{1'b0, zone1_threshold} <= {1'b0, $past(zone1_threshold)} + 9'h001)
		else $error("threshold raised by more than one degree");
	duty_hold_a: assert property (!duty_update |=> $stable(pwm_duty))
		else $error("duty changed without an update");
	duty_step_a: assert property (duty_update |=> (pwm_duty[7:0] == $past(computed_duty[7:0]))
		|| (pwm_duty[7:0] - $past(pwm_duty[7:0]) == 8'h10)
		|| ($past(pwm_duty[7:0]) - pwm_duty[7:0] == 8'h10))
		else $error("duty neither applied nor stepped");
endmodule
bind adaptive_fan_threshold_loop fan_loop_sva chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.prdata, .pready, .pslverr, .temp_valid, .duty_update, .computed_duty, .zone1_threshold,
	.zone2_threshold, .pwm_duty);
`default_nettype wire

// ### tb/fan_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module fan_side_model (
	input wire logic pclk,
	output logic temp_valid,
	output logic [9:0] zone1_temp,
	output logic [9:0] zone2_temp,
	output logic thermal_trip_pin_n,
	output logic duty_update,
	output logic [31:0] computed_duty
);
	initial begin
		temp_valid = 1'b0;
		zone1_temp = 10'h000;
		zone2_temp = 10'h000;
		thermal_trip_pin_n = 1'b1;
		duty_update = 1'b0;
		computed_duty = 32'h0000_0000;
	end
	// Readings stay latched between conversions, as a sensor result register does
	task automatic sense(input int n, input logic [9:0] t1, input logic [9:0] t2, input int gap);
		repeat (n) begin
			zone1_temp <= t1;
			zone2_temp <= t2;
			temp_valid <= 1'b1;
			@(posedge pclk);
			temp_valid <= 1'b0;
			repeat (gap) @(posedge pclk);
		end
	endtask
	// Open-drain line with a pull-up: released means high
	task automatic trip();
		thermal_trip_pin_n <= 1'b0;
		repeat (3) @(posedge pclk);
		thermal_trip_pin_n <= 1'b1;
		@(posedge pclk);
	endtask
	// Stale duties are inverted so a late sample cannot pass by luck
	task automatic duty(input logic [31:0] d);
		computed_duty <= d;
		duty_update <= 1'b1;
		@(posedge pclk);
		duty_update <= 1'b0;
		computed_duty <= ~d;
		@(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import fan_loop_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic temp_valid, thermal_trip_pin_n, duty_update;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, computed_duty, pwm_duty;
	logic [9:0] zone1_temp, zone2_temp;
	logic [7:0] zone1_threshold, zone2_threshold, rd;
	logic [31:0] cd [4] = '{32'h30808080, 32'h30808080, 32'h30050505, 32'h30050505};
	logic [31:0] ex [4] = '{32'h30101080, 32'h30202080, 32'h30101005, 32'h30050505};
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	adaptive_fan_threshold_loop dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .temp_valid, .zone1_temp, .zone2_temp, .thermal_trip_pin_n,
		.duty_update, .computed_duty, .zone1_threshold, .zone2_threshold, .pwm_duty);
	fan_side_model fan (.pclk, .temp_valid, .zone1_temp, .zone2_temp, .thermal_trip_pin_n,
		.duty_update, .computed_duty);
	task automatic results();
		$display("mismatches %0d comparisons %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t byte got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_duty(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t duty got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk_reg(rd, exp);
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	// Whole run needs well under two thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		@(posedge pclk);
		do_reset();
		rdc(IDX_ADAPT_CTRL, 8'h00);
		rdc(IDX_TARGET_Z1, 8'ha4);
		rdc(IDX_TARGET_Z2, 8'ha4);
		rdc(IDX_HYST, 8'h40);
		apb(1'b0, 8'h3f, 8'h00);
		chk_reg({7'h00, err}, 8'h01);
		wr(IDX_TARGET_Z1, 8'h70);
		wr(IDX_ADAPT_CTRL, 8'h01);
		// Zone 2 runs hot enough that it would move if its clear enable were ignored
		fan.sense(7, {8'h6e, 2'b00}, {8'hae, 2'b00}, 1);
		chk_reg(zone1_threshold, 8'h5a);
		fan.sense(1, {8'h6f, 2'b00}, {8'haf, 2'b00}, 1);
		chk_reg(zone1_threshold, 8'h58);
		fan.sense(7, {8'h72, 2'b00}, {8'hb2, 2'b00}, 3);
		chk_reg(zone1_threshold, 8'h58);
		fan.sense(1, {8'h72, 2'b01}, {8'hb2, 2'b01}, 1);
		chk_reg(zone1_threshold, 8'h57);
		chk_reg(zone2_threshold, 8'h5a);
		fan.trip();
		rdc(IDX_TARGET_Z1, 8'h70);
		rdc(IDX_STATUS, 8'h00);
		do_reset();
		wr(IDX_ADAPT_CTRL, 8'h03);
		wr(IDX_TARGET_Z1, 8'h62);
		wr(IDX_LOW_Z2, 8'h80);
		wr(IDX_TARGET_Z2, 8'h70);
		wr(IDX_HIGH_Z2, 8'h5b);
		fan.sense(16, {8'h60, 2'b00}, {8'h5c, 2'b00}, 1);
		chk_reg(zone2_threshold, 8'h5b);
		fan.sense(16, {8'h60, 2'b00}, {8'h5c, 2'b00}, 1);
		chk_reg(zone1_threshold, 8'h5a);
		chk_reg(zone2_threshold, 8'h5b);
		do_reset();
		wr(IDX_ADAPT_CTRL, 8'h07);
		wr(IDX_CYCLE_CTRL, 8'h08);
		wr(IDX_TARGET_Z1, 8'h40);
		wr(IDX_TARGET_Z2, 8'h10);
		wr(IDX_THRESH_Z2, 8'h01);
		rdc(IDX_THRESH_Z2, 8'h01);
		// Zone 2 uses n of 16, so its first long cycle falls on pulse 32
		fan.sense(16, {8'h50, 2'b00}, {8'h20, 2'b00}, 1);
		chk_reg(zone2_threshold, 8'h01);
		fan.sense(16, {8'h50, 2'b00}, {8'h20, 2'b00}, 1);
		chk_reg(zone2_threshold, 8'h00);
		fan.sense(32, {8'h50, 2'b00}, {8'h20, 2'b00}, 1);
		chk_reg(zone1_threshold, 8'h5a);
		chk_reg(zone2_threshold, 8'h00);
		fan.trip();
		rdc(IDX_TARGET_Z1, 8'h50);
		rdc(IDX_TARGET_Z2, 8'h10);
		rdc(IDX_STATUS, 8'h01);
		wr(IDX_STATUS, 8'h01);
		rdc(IDX_STATUS, 8'h00);
		rdc(IDX_TEMP_Z1, 8'h50);
		wr(IDX_ACOUSTIC_A, 8'h02);
		wr(IDX_ACOUSTIC_B, 8'h01);
		for (int i = 0; i < 4; i++) begin
			fan.duty(cd[i]);
			chk_duty(pwm_duty, ex[i]);
		end
		results();
	end
endmodule
`default_nettype wire
